// file: rtl/channel_calibration_regs.sv
// Channel 5 offset, gain and input-select registers with checksum readback
`timescale 1ns/1ps
`include "ch5_cal_consts.svh"

module channel_calibration_regs
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register access
    input ch5_cal_pkg::reg_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    // Checksum computed elsewhere in the device
    input wire logic [15:0] crc_value,
    // Conversion path
    input wire logic sample_valid,
    input wire logic signed [23:0] sample_in,
    output ch5_cal_pkg::cal_coef_t coef,
    output logic signed [23:0] sample_out,
    output logic sample_out_valid
);
    import ch5_cal_pkg::*;

    // Stored fields; the low bytes of the low registers have no storage,
    // which makes them read-only zero without any extra masking logic
    logic [15:0] ch5_offset_high_bits;
    logic [7:0] ch5_offset_low_bits;
    logic [15:0] ch5_gain_high_bits;
    logic [7:0] ch5_gain_low_bits;
    logic [15:0] reserved_reg;
    logic [15:0] checksum;
    input_sel_t ch5_input_select;

    // Write strobe aimed at one register address
    function automatic logic wr_hit(reg_req_t r, logic [5:0] addr);
        return r.wr && (r.addr == addr);
    endfunction : wr_hit

    // Upper byte of a write word, the only stored part of a low register
    function automatic logic [7:0] upper_byte(logic [15:0] word);
        return word[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
    endfunction : upper_byte

    // Low register image: stored byte above a byte that always reads zero
    function automatic logic [15:0] low_image(logic [7:0] stored);
        return {stored, 8'h00};
    endfunction : low_image

    // Clamp a scaled result into the signed 24-bit output range.
    // Saturation instead of wrap keeps a gross calibration error visible
    // as a rail value rather than as a sign flip.
    function automatic logic signed [23:0] clamp24(logic signed [26:0] v);
        logic signed [23:0] result;
        if (v > 27'sh07FFFFF)
            result = 24'sh7FFFFF;
        else if (v < -27'sh0800000)
            result = 24'sh800000;
        else
            result = v[23:0];
        return result;
    endfunction : clamp24

    // Address decode, one strobe per writable register.
    // The checksum address has no strobe, so writes to it are dropped.
    wire logic wr_cfg = wr_hit(req, `ADDR_CFG);
    wire logic wr_oh = wr_hit(req, `ADDR_OCAL_HIGH);
    wire logic wr_ol = wr_hit(req, `ADDR_OCAL_LOW);
    wire logic wr_gh = wr_hit(req, `ADDR_GCAL_HIGH);
    wire logic wr_gl = wr_hit(req, `ADDR_GCAL_LOW);
    wire logic wr_rs = wr_hit(req, `ADDR_RSVD);

    // Data fields carried by a write
    wire logic [7:0] wr_upper = upper_byte(req.wdata);
    wire logic [1:0] wr_sel = req.wdata[`SEL_MSB:`SEL_LSB];

    // Offset high half, bits 23:8 of the offset word
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ch5_offset_high_bits <= `RST_OCAL_HIGH;
        else if (wr_oh)
            ch5_offset_high_bits <= req.wdata;
    end

    // Offset low half, bits 7:0 of the offset word
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ch5_offset_low_bits <= `RST_OCAL_LOW;
        else if (wr_ol)
            ch5_offset_low_bits <= wr_upper;
    end

    // Gain high half; resets to unity so an untouched channel passes through
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ch5_gain_high_bits <= `RST_GCAL_HIGH;
        else if (wr_gh)
            ch5_gain_high_bits <= req.wdata;
    end

    // Gain low half, bits 7:0 of the gain word
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ch5_gain_low_bits <= `RST_GCAL_LOW;
        else if (wr_gl)
            ch5_gain_low_bits <= wr_upper;
    end

    // Reserved word keeps whatever is written; software is expected
    // to write zero, and a nonzero value changes nothing else here
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            reserved_reg <= `RST_RSVD;
        else if (wr_rs)
            reserved_reg <= req.wdata;
    end

    // Input source select
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ch5_input_select <= input_sel_t'(`RST_SEL);
        else if (wr_cfg)
            ch5_input_select <= input_sel_t'(wr_sel);
    end

    // Checksum snapshot, zero until the first edge after reset.
    // The copy costs one cycle of lag but keeps the read mux registered.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            checksum <= `RST_CHECKSUM;
        else
            checksum <= crc_value;
    end

    // Read mux; unmapped addresses read zero
    logic [15:0] next_rdata;
    always_comb
    begin
        case (req.addr)
            `ADDR_CFG: next_rdata = {14'h0, ch5_input_select};
            `ADDR_OCAL_HIGH: next_rdata = ch5_offset_high_bits;
            `ADDR_OCAL_LOW: next_rdata = low_image(ch5_offset_low_bits);
            `ADDR_GCAL_HIGH: next_rdata = ch5_gain_high_bits;
            `ADDR_GCAL_LOW: next_rdata = low_image(ch5_gain_low_bits);
            `ADDR_CHECKSUM: next_rdata = checksum;
            `ADDR_RSVD: next_rdata = reserved_reg;
            default: next_rdata = 16'h0000;
        endcase
    end

    // Read data holds until the next read, so software may sample late
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= `RST_RDATA;
        else if (req.rd)
            rdata <= next_rdata;
    end

    // Read valid pulses one cycle after each read strobe
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rvalid <= 1'b0;
        else
            rvalid <= req.rd;
    end

    // Coefficient assembly; halves update independently, so a host
    // changing a coefficient live sees a mixed word until both halves are written
    assign coef.offset = {ch5_offset_high_bits, ch5_offset_low_bits};
    assign coef.gain = {ch5_gain_high_bits, ch5_gain_low_bits};
    assign coef.sel = ch5_input_select;

    // Correction: (x + offset) * gain / 2^23, saturated to 24 bits.
    // 8000_00h is unity; top code is just below two.
    // The sum is one bit wider so offset plus sample cannot wrap,
    // and the gain gets a zero sign bit since it is unsigned.
    wire logic signed [24:0] sum = 25'(sample_in) + 25'(coef.offset);
    wire logic signed [49:0] prod = 50'(sum) * $signed({1'b0, coef.gain});
    wire logic signed [26:0] scaled = prod[49:23];

    // Saturated result ready for the output register
    wire logic signed [23:0] next_sample = clamp24(scaled);

    // Output strobe follows the input strobe by one cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            sample_out_valid <= 1'b0;
        else
            sample_out_valid <= sample_valid;
    end

    // Corrected sample holds until the next input sample
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            sample_out <= `RST_SAMPLE;
        else if (sample_valid)
            sample_out <= next_sample;
    end

endmodule : channel_calibration_regs

// file: pkg/ch5_cal_consts.svh
// Register offsets, field positions and reset values of the channel 5 bank
`ifndef CH5_CAL_CONSTS_SVH
`define CH5_CAL_CONSTS_SVH

`define ADDR_CFG 6'h22
`define ADDR_OCAL_HIGH 6'h23
`define ADDR_OCAL_LOW 6'h24
`define ADDR_GCAL_HIGH 6'h25
`define ADDR_GCAL_LOW 6'h26
`define ADDR_CHECKSUM 6'h3E
`define ADDR_RSVD 6'h3F

`define RST_OCAL_HIGH 16'h0000
`define RST_OCAL_LOW 8'h00
`define RST_GCAL_HIGH 16'h8000
`define RST_GCAL_LOW 8'h00
`define RST_RSVD 16'h0000
`define RST_SEL 2'h0
`define RST_CHECKSUM 16'h0000
`define RST_RDATA 16'h0000
`define RST_SAMPLE 24'h000000

`define LOW_FIELD_MSB 15
`define LOW_FIELD_LSB 8
`define SEL_MSB 1
`define SEL_LSB 0

`endif

// file: pkg/ch5_cal_pkg.sv
// Types shared by the channel 5 calibration bank
package ch5_cal_pkg;

    typedef enum logic [1:0]
    {
        SEL_PINS = 2'h0,
        SEL_SHORT = 2'h1,
        SEL_TEST_POS = 2'h2,
        SEL_TEST_NEG = 2'h3
    } input_sel_t;

    // Register access from the serial interface
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // Coefficients handed to the conversion path
    typedef struct packed
    {
        logic signed [23:0] offset;
        logic [23:0] gain;
        input_sel_t sel;
    } cal_coef_t;

endpackage : ch5_cal_pkg

// file: test/ch5_cal_sva.sv
// Port checker for the channel 5 calibration bank
`timescale 1ns/1ps
module ch5_cal_sva
(
    // Watched ports
    input wire logic sys_clk,
    input wire logic arst_n,
    input ch5_cal_pkg::reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic [15:0] crc_value,
    input wire logic sample_valid,
    input wire logic signed [23:0] sample_in,
    input ch5_cal_pkg::cal_coef_t coef,
    input wire logic signed [23:0] sample_out,
    input wire logic sample_out_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Short names for the request fields
    wire w = req.wr;
    wire [5:0] a = req.addr;
    a_off_high: assert property (w && a == 6'h23
        |=> coef.offset[23:8] == $past(req.wdata)) else $error("off hi");
    a_off_low: assert property (w && a == 6'h24
        |=> coef.offset[7:0] == $past(req.wdata[15:8])) else $error("off lo");
    a_gain_high: assert property (w && a == 6'h25
        |=> coef.gain[23:8] == $past(req.wdata)) else $error("gain hi");
    a_gain_low: assert property (w && a == 6'h26
        |=> coef.gain[7:0] == $past(req.wdata[15:8])) else $error("gain lo");
    a_low_zero: assert property (req.rd && (a == 6'h24 || a == 6'h26)
        |=> rvalid && rdata[7:0] == 8'h00) else $error("low byte");
    // Checksum is a registered copy, so it lags the input by one edge
    a_crc_read: assert property (req.rd && a == 6'h3E && $past(arst_n)
        |=> rdata == $past(crc_value, 2)) else $error("checksum");
    a_sel_code: assert property (w && a == 6'h22
        |=> coef.sel == $past(req.wdata[1:0])) else $error("select");
    a_unity_pass: assert property (sample_valid && coef[49:2] == 48'h800000
        |=> sample_out_valid && sample_out == $past(sample_in)) else $error("unity");
endmodule : ch5_cal_sva
bind channel_calibration_regs ch5_cal_sva chk
(
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .crc_value(crc_value),
    .sample_valid(sample_valid),
    .sample_in(sample_in),
    .coef(coef),
    .sample_out(sample_out),
    .sample_out_valid(sample_out_valid)
);

// file: test/channel_calibration_regs_test.sv
// Random and corner tests of the channel 5 calibration bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %0t %h %h", $time, g, e); end end
module channel_calibration_regs_test;
    import ch5_cal_pkg::*;
    logic sys_clk = 0;
    logic arst_n = 0;
    reg_req_t req = '0;
    logic [15:0] crc_value = 16'h0000, rdata, x, y;
    logic [15:0] r [4];
    logic sample_valid = 0;
    logic signed [23:0] sample_in = '0, sample_out;
    logic rvalid, sample_out_valid;
    cal_coef_t coef;
    int err_count, n_tests, i;
    channel_calibration_regs dut
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .req(req),
        .rdata(rdata),
        .rvalid(rvalid),
        .crc_value(crc_value),
        .sample_valid(sample_valid),
        .sample_in(sample_in),
        .coef(coef),
        .sample_out(sample_out),
        .sample_out_valid(sample_out_valid)
    );
    always #2.5 sys_clk = ~sys_clk;
    // Verdict and end of run
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // One register access; a read leaves its data in y
    task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{w, !w, a, d};
        @(posedge sys_clk);
        req <= '0;
        #1;
        for (i = 0; i < 4 && !w && rvalid !== 1'b1; i++) @(posedge sys_clk) #1;
        if (i == 4)
        begin
            err_count++;
            results();
        end
        y = rdata;
    endtask : acc
    // Corrected sample, saturated to 24 bits
    function automatic logic signed [23:0] fx(logic signed [23:0] s, o, logic [23:0] g);
        logic signed [49:0] p;
        p = ((s + o) * $signed({1'b0, g})) >>> 23;
        return p > 50'sh7FFFFF ? 24'h7FFFFF : p < -50'sh800000 ? 24'h800000 : p[23:0];
    endfunction : fx
    initial
    begin
        x = $urandom(59110);
        repeat (8) @(posedge sys_clk);
        arst_n <= 1;
        // Checksum write is dropped, so every read shows its reset value
        acc(1, 6'h3E, 16'hFFFF);
        for (int k = 0; k < 6; k++)
        begin
            acc(0, k < 4 ? 6'(6'h23 + k) : 6'(6'h3A + k), 0);
            `CHK(y, k == 2 ? 16'h8000 : 16'h0000)
        end
        $display("reset test done");
        for (int k = 0; k < 30; k++)
        begin
            if (k % 10 == 9)
                acc(1, k > 10 ? 6'h23 : 6'h25, 16'($urandom));
            @(posedge sys_clk);
            sample_valid <= 1;
            sample_in <= k ? 24'($urandom) : 24'h800000;
            @(posedge sys_clk);
            sample_valid <= 0;
            #1;
            `CHK(sample_out, fx(sample_in, coef.offset, coef.gain))
            `CHK(sample_out_valid, 1'b1)
        end
        $display("sample test done");
        for (int k = 0; k < 24; k++)
        begin
            x = $urandom;
            r[k % 4] = x;
            acc(1, 6'(6'h23 + k % 4), x);
            acc(0, 6'(6'h23 + k % 4), 0);
            `CHK(y, k % 2 ? {x[15:8], 8'h00} : x)
        end
        `CHK(coef[49:2], {r[0], r[1][15:8], r[2], r[3][15:8]})
        for (int k = 0; k < 4; k++)
        begin
            acc(1, 6'h22, 16'(k));
            `CHK(coef.sel, 2'(k))
            acc(0, 6'h22, 0);
            `CHK(y, 16'(k))
        end
        @(posedge sys_clk);
        crc_value <= 16'($urandom);
        acc(1, 6'h3F, 16'h0000);
        acc(0, 6'h3F, 0);
        `CHK(y, 16'h0000)
        acc(0, 6'h3E, 0);
        `CHK(y, crc_value)
        $display("register test done");
        // Reset in mid-run brings the coefficients back to their defaults
        @(posedge sys_clk);
        arst_n <= 0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1;
        #1;
        `CHK(coef[49:2], 48'h000000800000)
        `CHK(sample_out_valid, 1'b0)
        acc(0, 6'h3F, 0);
        `CHK(y, 16'h0000)
        $display("midrun reset test done");
        results();
    end
endmodule : channel_calibration_regs_test
